/* File: seq_pkg.sv */
// Constants, states and register map of the power-up and fault sequencer.
// Assumes a single 50 MHz clock shared by the whole controller.

package seq_pkg;

	//----------------------------------------------------------------
	// Timing
	//----------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 50;
	localparam int unsigned WARMUP_US     = 150;
	localparam int unsigned BOOT_US       = 10;
	localparam int unsigned BURST_MS      = 200;
	localparam int unsigned PAUSE_S       = 1;
	localparam int unsigned AVG_SHORT_MS  = 2;
	localparam int unsigned AVG_LONG_MS   = 50;
	localparam int unsigned WARMUP_CYC    = WARMUP_US * CLK_MHZ;
	localparam int unsigned BOOT_CYC      = BOOT_US * CLK_MHZ;
	localparam int unsigned BURST_CYC     = BURST_MS * CLK_MHZ * 1000;
	localparam int unsigned PAUSE_CYC     = PAUSE_S * CLK_MHZ * 1000000;
	localparam int unsigned AVG_SHORT_CYC = AVG_SHORT_MS * CLK_MHZ * 1000;
	localparam int unsigned AVG_LONG_CYC  = AVG_LONG_MS * CLK_MHZ * 1000;
	localparam int unsigned TIMER_W       = 26;

	//----------------------------------------------------------------
	// States
	//----------------------------------------------------------------
	typedef enum logic [2:0] {
		TRIM_LOAD, HV_SOURCE_ON, HV_SOURCE_OFF, ANALOG_WARMUP,
		BOOT_CHARGE, STEADY_RUN, LIGHT_LOAD_RUN, ERROR_PAUSE
	} seq_state_e;

	//----------------------------------------------------------------
	// Drive vector bit positions
	//----------------------------------------------------------------
	localparam int unsigned DRV_W      = 7;
	localparam int unsigned DRV_WAVE   = 6;
	localparam int unsigned DRV_AUX    = 5;
	localparam int unsigned DRV_CLAMP  = 4;
	localparam int unsigned DRV_SOFT   = 3;
	localparam int unsigned DRV_PASS   = 2;
	localparam int unsigned DRV_HVHIGH = 1;
	localparam int unsigned DRV_LOWSIDE = 0;
	localparam logic [DRV_W-1:0] DRV_RESET = 7'h14;

	//----------------------------------------------------------------
	// Synchronised input bit positions
	//----------------------------------------------------------------
	localparam int unsigned SY_W     = 11;
	localparam int unsigned SY_OTP   = 0;
	localparam int unsigned SY_AVGS  = 1;
	localparam int unsigned SY_AVGL  = 2;
	localparam int unsigned SY_BSTART = 3;
	localparam int unsigned SY_BSTOP = 4;
	localparam int unsigned SY_BOV   = 5;
	localparam int unsigned SY_AUXUV = 6;
	localparam int unsigned SY_RESTART = 7;
	localparam int unsigned SY_SWITCH = 8;
	localparam int unsigned SY_FB    = 9;
	localparam int unsigned SY_ZC    = 10;

	//----------------------------------------------------------------
	// Register map
	//----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
	localparam int unsigned CTRL_EXT_BIAS = 0;
	localparam int unsigned ST_STATE_LSB  = 0;
	localparam int unsigned ST_SYNC_LSB   = 8;
	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned IRQ_FAULT     = 0;
	localparam int unsigned IRQ_RESTART   = 1;
	localparam int unsigned IRQ_RUN       = 2;
	localparam int unsigned IRQ_BURST_TO  = 3;

endpackage

/* File: system_state_fault_sequencer.sv */
// Power-up and fault sequencer of the resonant converter controller.
// Assumes analog comparator flags arrive asynchronously; trim, soft-start,
// unplug and waveform generator flags come from logic on clk.

`timescale 1ns/100ps

module system_state_fault_sequencer import seq_pkg::*; #(
	parameter int unsigned WARMUP_CYCLES    = WARMUP_CYC,
	parameter int unsigned BOOT_CYCLES      = BOOT_CYC,
	parameter int unsigned BURST_CYCLES     = BURST_CYC,
	parameter int unsigned PAUSE_CYCLES     = PAUSE_CYC,
	parameter int unsigned AVG_SHORT_CYCLES = AVG_SHORT_CYC,
	parameter int unsigned AVG_LONG_CYCLES  = AVG_LONG_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Analog comparator flags
	input  wire logic              overTemperature,
	input  wire logic              avgOvercurrentShort,
	input  wire logic              avgOvercurrentLong,
	input  wire logic              bulkAboveStart,
	input  wire logic              bulkBelowStop,
	input  wire logic              bulkOvervoltage,
	input  wire logic              auxRegUndervoltage,
	input  wire logic              supplyBelowRestart,
	input  wire logic              supplyAboveSwitchThreshold,
	input  wire logic              feedbackBelowBurstThreshold,
	input  wire logic              lineZeroCrossSeen,
	// Same-clock flags
	input  wire logic              systemReady,
	input  wire logic              softStartDone,
	input  wire logic              outputOvervoltage,
	input  wire logic              peakOvercurrent,
	input  wire logic              lineCapDischargeReq,
	// Enables
	output logic                   waveformEnable,
	output logic                   auxRegulatorEnable,
	output logic                   supplyClampEnable,
	output logic                   softStartEnable,
	output logic                   hvPassDeviceEnable,
	output logic                   hvHighCurrentLevel,
	output logic                   lowSideHold,
	output logic                   lineCapDischarge,
	output logic                   externalBiasMode,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWrEn,
	input  wire logic              regRdEn,
	output logic      [31:0]       regRdData,
	// Interrupt
	output logic                   irq
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	//----------------------------------------------------------------
	// Drive levels per state
	//----------------------------------------------------------------
	function automatic logic [DRV_W-1:0] driveFor(input seq_state_e s);
		logic [DRV_W-1:0] d;
		d = '0;
		unique case (s)
			TRIM_LOAD: begin
				d[DRV_CLAMP] = 1'b1;
				d[DRV_PASS]  = 1'b1;
			end
			HV_SOURCE_ON: begin
				d[DRV_PASS]   = 1'b1;
				d[DRV_HVHIGH] = 1'b1;
			end
			HV_SOURCE_OFF, ANALOG_WARMUP: begin
				d[DRV_AUX] = 1'b1;
			end
			BOOT_CHARGE: begin
				d[DRV_AUX]     = 1'b1;
				d[DRV_LOWSIDE] = 1'b1;
			end
			STEADY_RUN, LIGHT_LOAD_RUN: begin
				d[DRV_WAVE] = 1'b1;
				d[DRV_AUX]  = 1'b1;
				d[DRV_SOFT] = 1'b1;
			end
			ERROR_PAUSE: d = '0;
		endcase
		return d;
	endfunction

	//----------------------------------------------------------------
	// Input synchronisers
	//----------------------------------------------------------------
	logic [SY_W-1:0] asyncIn;
	logic [SY_W-1:0] meta_q;
	logic [SY_W-1:0] sync_q;

	assign asyncIn = {lineZeroCrossSeen, feedbackBelowBurstThreshold,
		supplyAboveSwitchThreshold, supplyBelowRestart, auxRegUndervoltage,
		bulkOvervoltage, bulkBelowStop, bulkAboveStart, avgOvercurrentLong,
		avgOvercurrentShort, overTemperature};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= asyncIn;
			sync_q <= meta_q;
		end
	end

	//----------------------------------------------------------------
	// Average overcurrent qualification
	//----------------------------------------------------------------
	logic [1:0] avgExpired;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_avg
			localparam int unsigned LIM = (i == 0) ? AVG_SHORT_CYCLES
				: AVG_LONG_CYCLES;
			logic [TIMER_W-1:0] cnt_q;
			logic               level;
			assign level = sync_q[SY_AVGS + i];
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_q <= '0;
				end else if (!level) begin
					cnt_q <= '0;
				end else if (cnt_q != TIMER_W'(LIM)) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
			assign avgExpired[i] = (cnt_q == TIMER_W'(LIM));
		end
	endgenerate

	//----------------------------------------------------------------
	// Fault and transition conditions
	//----------------------------------------------------------------
	logic otp;
	logic restartReq;
	logic runFault;
	logic startOk;
	logic fbLow;

	assign otp        = sync_q[SY_OTP];
	assign restartReq = sync_q[SY_RESTART];
	assign fbLow      = sync_q[SY_FB];
	assign startOk    = sync_q[SY_BSTART] & ~sync_q[SY_BSTOP]
		& ~sync_q[SY_BOV] & ~sync_q[SY_AUXUV];
	// Fast faults are already qualified by the waveform generator
	assign runFault   = otp | sync_q[SY_BOV] | sync_q[SY_BSTOP]
		| outputOvervoltage | peakOvercurrent
		| (|avgExpired) | sync_q[SY_AUXUV];

	//----------------------------------------------------------------
	// State machine
	//----------------------------------------------------------------
	seq_state_e         state_q;
	seq_state_e         state_d;
	logic [TIMER_W-1:0] timer_q;
	logic               timerDone;

	always_comb begin
		unique case (state_q)
			ANALOG_WARMUP:  timerDone = timer_q == TIMER_W'(WARMUP_CYCLES - 1);
			BOOT_CHARGE:    timerDone = timer_q == TIMER_W'(BOOT_CYCLES - 1);
			LIGHT_LOAD_RUN: timerDone = timer_q == TIMER_W'(BURST_CYCLES - 1);
			ERROR_PAUSE:    timerDone = timer_q == TIMER_W'(PAUSE_CYCLES - 1);
			default:        timerDone = 1'b0;
		endcase
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			TRIM_LOAD: begin
				if (systemReady) state_d = HV_SOURCE_ON;
			end
			HV_SOURCE_ON: begin
				if (otp) begin
					state_d = ERROR_PAUSE;
				end else if (sync_q[SY_SWITCH] && !restartReq) begin
					state_d = HV_SOURCE_OFF;
				end
			end
			HV_SOURCE_OFF: begin
				if (otp) begin
					state_d = ERROR_PAUSE;
				end else if (restartReq) begin
					state_d = HV_SOURCE_ON;
				end else if (startOk) begin
					state_d = ANALOG_WARMUP;
				end
			end
			ANALOG_WARMUP, BOOT_CHARGE: begin
				if (otp || sync_q[SY_BOV]) begin
					state_d = ERROR_PAUSE;
				end else if (restartReq) begin
					state_d = HV_SOURCE_ON;
				end else if (timerDone) begin
					state_d = (state_q == ANALOG_WARMUP) ? BOOT_CHARGE
						: STEADY_RUN;
				end
			end
			STEADY_RUN: begin
				if (runFault) begin
					state_d = ERROR_PAUSE;
				end else if (restartReq) begin
					state_d = HV_SOURCE_ON;
				end else if (softStartDone && fbLow) begin
					state_d = LIGHT_LOAD_RUN;
				end
			end
			LIGHT_LOAD_RUN: begin
				if (runFault || timerDone) begin
					state_d = ERROR_PAUSE;
				end else if (restartReq) begin
					state_d = HV_SOURCE_ON;
				end else if (!fbLow) begin
					state_d = STEADY_RUN;
				end
			end
			ERROR_PAUSE: begin
				if (timerDone) state_d = HV_SOURCE_ON;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= TRIM_LOAD;
		end else begin
			state_q <= state_d;
		end
	end

	// Dwell timer, cleared on every state change
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_q <= '0;
		end else if (state_d != state_q) begin
			timer_q <= '0;
		end else if (state_q inside {ANALOG_WARMUP, BOOT_CHARGE,
				LIGHT_LOAD_RUN, ERROR_PAUSE}) begin
			timer_q <= timer_q + 1'b1;
		end
	end

	//----------------------------------------------------------------
	// Output registers
	//----------------------------------------------------------------
	logic [DRV_W-1:0] drive_q;
	logic             capDischarge_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_q <= DRV_RESET;
		end else begin
			drive_q <= driveFor(state_d);
		end
	end

	// Unplug detection alone steers the discharge path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capDischarge_q <= 1'b0;
		end else begin
			capDischarge_q <= lineCapDischargeReq;
		end
	end

	assign waveformEnable     = drive_q[DRV_WAVE];
	assign auxRegulatorEnable = drive_q[DRV_AUX];
	assign supplyClampEnable  = drive_q[DRV_CLAMP];
	assign softStartEnable    = drive_q[DRV_SOFT];
	assign hvPassDeviceEnable = drive_q[DRV_PASS];
	assign hvHighCurrentLevel = drive_q[DRV_HVHIGH];
	assign lowSideHold        = drive_q[DRV_LOWSIDE];
	assign lineCapDischarge   = capDischarge_q;

	//----------------------------------------------------------------
	// Registers and interrupt
	//----------------------------------------------------------------
	logic             extBias_q;
	logic [IRQ_W-1:0] irqStat_q;
	logic [IRQ_W-1:0] irqStat_d;
	logic [IRQ_W-1:0] irqMask_q;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic [31:0]      rdData_q;
	logic             irq_q;

	always_comb begin
		events = '0;
		events[IRQ_FAULT]   = state_d == ERROR_PAUSE
			&& state_q != ERROR_PAUSE;
		events[IRQ_RESTART] = state_d == HV_SOURCE_ON
			&& state_q != HV_SOURCE_ON && state_q != TRIM_LOAD;
		events[IRQ_RUN]     = state_q == BOOT_CHARGE
			&& state_d == STEADY_RUN;
		events[IRQ_BURST_TO] = state_q == LIGHT_LOAD_RUN && timerDone;
		w1c = (regWrEn && regAddr == REG_IRQ_STAT)
			? regWrData[IRQ_W-1:0] : '0;
		// Set wins over a clear in the same cycle
		irqStat_d = (irqStat_q & ~w1c) | events;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			extBias_q <= 1'b0;
			irqMask_q <= '0;
		end else if (regWrEn) begin
			if (regAddr == REG_CTRL) begin
				extBias_q <= regWrData[CTRL_EXT_BIAS];
			end
			if (regAddr == REG_IRQ_MASK) begin
				irqMask_q <= regWrData[IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStat_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			irqStat_q <= irqStat_d;
			irq_q     <= |(irqStat_d & irqMask_q);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_q <= '0;
		end else begin
			rdData_q <= '0;
			if (regRdEn) begin
				unique case (regAddr)
					REG_CTRL:     rdData_q[CTRL_EXT_BIAS] <= extBias_q;
					REG_STATUS: begin
						rdData_q[ST_STATE_LSB +: $bits(seq_state_e)] <= state_q;
						rdData_q[ST_SYNC_LSB +: SY_W] <= sync_q;
					end
					REG_IRQ_STAT: rdData_q[IRQ_W-1:0] <= irqStat_q;
					REG_IRQ_MASK: rdData_q[IRQ_W-1:0] <= irqMask_q;
					default:      rdData_q <= '0;
				endcase
			end
		end
	end

	assign externalBiasMode = extBias_q;
	assign regRdData        = rdData_q;
	assign irq              = irq_q;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	property p_trim_drive;
		state_q == TRIM_LOAD |-> supplyClampEnable && hvPassDeviceEnable
			&& !waveformEnable && !auxRegulatorEnable && !softStartEnable;
	endproperty
	a_trim_drive: assert property (p_trim_drive)
		else $error("trim-load drive levels wrong");

	property p_trim_hold;
		state_q == TRIM_LOAD && !systemReady |=> state_q == TRIM_LOAD;
	endproperty
	a_trim_hold: assert property (p_trim_hold)
		else $error("left trim-load without system ready");

	property p_hv_off;
		state_q == HV_SOURCE_ON && !otp && sync_q[SY_SWITCH] && !restartReq
			|=> state_q == HV_SOURCE_OFF && !hvPassDeviceEnable
			&& auxRegulatorEnable;
	endproperty
	a_hv_off: assert property (p_hv_off)
		else $error("pass device not released at switch level");

	property p_warmup_len;
		$rose(state_q == ANALOG_WARMUP) ##0
			(!otp && !sync_q[SY_BOV] && !restartReq) [*8]
			|-> state_q == ANALOG_WARMUP && timer_q == TIMER_W'(7);
	endproperty
	a_warmup_len: assert property (p_warmup_len)
		else $error("warm-up left early");

	property p_pause_drive;
		state_q == ERROR_PAUSE |-> !waveformEnable && !auxRegulatorEnable
			&& !supplyClampEnable && !softStartEnable && !hvPassDeviceEnable;
	endproperty
	a_pause_drive: assert property (p_pause_drive)
		else $error("enable high during error pause");

	property p_run_fault;
		state_q inside {STEADY_RUN, LIGHT_LOAD_RUN} && runFault
			|=> state_q == ERROR_PAUSE ##1 !waveformEnable;
	endproperty
	a_run_fault: assert property (p_run_fault)
		else $error("run fault not taken");

	property p_burst_timeout;
		state_q == LIGHT_LOAD_RUN && timer_q == TIMER_W'(BURST_CYCLES - 1)
			|=> state_q == ERROR_PAUSE;
	endproperty
	a_burst_timeout: assert property (p_burst_timeout)
		else $error("burst timeout missed");

	property p_light_exit;
		state_q == LIGHT_LOAD_RUN && !fbLow && !runFault && !restartReq
			&& !timerDone |=> state_q == STEADY_RUN && timer_q == '0;
	endproperty
	a_light_exit: assert property (p_light_exit)
		else $error("light-load exit wrong");

	property p_hv_high;
		hvHighCurrentLevel == (state_q == HV_SOURCE_ON);
	endproperty
	a_hv_high: assert property (p_hv_high)
		else $error("high start-up current mismatch");

	property p_discharge;
		lineCapDischarge == $past(lineCapDischargeReq);
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("discharge not following request");

endmodule

/* File: far_side_model.sv */
// Far-side model: trim loading, soft start and waveform generator faults.
// Assumes one clock shared with the sequencer.

`timescale 1ns/100ps

module far_side_model #(
	parameter int READY_DLY = 12,
	parameter int SS_DLY    = 6
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// From sequencer and bench
	input  wire logic       softStartEnable,
	input  wire logic [1:0] fastFaultReq,
	// To sequencer
	output logic            systemReady,
	output logic            softStartDone,
	output logic            outputOvervoltage,
	output logic            peakOvercurrent
);
	int readyCnt;
	int ssCnt;

	//----------------------------------------------------------------
	// Trim load, soft start and fast faults
	//----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			readyCnt <= 0;
			ssCnt <= 0;
			systemReady <= 1'b0;
			softStartDone <= 1'b0;
			outputOvervoltage <= 1'b0;
			peakOvercurrent <= 1'b0;
		end else begin
			if (readyCnt < READY_DLY)
				readyCnt <= readyCnt + 1;
			systemReady <= (readyCnt == READY_DLY);
			ssCnt <= softStartEnable ? ssCnt + 1 : 0;
			softStartDone <= softStartEnable && (ssCnt >= SS_DLY);
			// Generator passes its own faults on after one cycle
			outputOvervoltage <= fastFaultReq[0];
			peakOvercurrent <= fastFaultReq[1];
		end
	end
endmodule

/* File: system_state_fault_sequencer_tb_top.sv */
// Bench for the sequencer: walks start-up, burst, restart and faults.
// Assumes the far-side model supplies trim, soft start and fast faults.

`timescale 1ns/100ps

module system_state_fault_sequencer_tb_top import seq_pkg::*;;
	localparam int WU = 10;
	localparam int BT = 4;
	localparam int BU = 20;
	localparam int PS = 20;
	localparam int AS = 5;
	localparam int AL = 9;

	logic clk = 0, reset_n = 0, overTemperature = 0, avgOvercurrentShort = 0;
	logic avgOvercurrentLong = 0, bulkAboveStart = 0, bulkBelowStop = 0;
	logic bulkOvervoltage = 0, auxRegUndervoltage = 0, supplyBelowRestart = 0;
	logic supplyAboveSwitchThreshold = 0, feedbackBelowBurstThreshold = 0;
	logic lineZeroCrossSeen = 0, lineCapDischargeReq = 0;
	logic systemReady, softStartDone, outputOvervoltage, peakOvercurrent;
	logic waveformEnable, auxRegulatorEnable, supplyClampEnable, irq;
	logic softStartEnable, hvPassDeviceEnable, hvHighCurrentLevel;
	logic lowSideHold, lineCapDischarge, externalBiasMode;
	logic [1:0]        fastFaultReq = 0;
	logic [ADDR_W-1:0] regAddr = 0;
	logic [31:0]       regWrData = 0;
	logic              regWrEn = 0;
	logic              regRdEn = 0;
	logic [31:0]       regRdData;
	int                fails = 0;
	int                checksDone = 0;

	always #10 clk = ~clk;

	system_state_fault_sequencer #(.WARMUP_CYCLES(WU), .BOOT_CYCLES(BT),
		.BURST_CYCLES(BU), .PAUSE_CYCLES(PS), .AVG_SHORT_CYCLES(AS),
		.AVG_LONG_CYCLES(AL)) i_dut (.clk, .reset_n, .overTemperature,
		.avgOvercurrentShort, .avgOvercurrentLong, .bulkAboveStart,
		.bulkBelowStop, .bulkOvervoltage, .auxRegUndervoltage,
		.supplyBelowRestart, .supplyAboveSwitchThreshold,
		.feedbackBelowBurstThreshold, .lineZeroCrossSeen, .systemReady,
		.softStartDone, .outputOvervoltage, .peakOvercurrent,
		.lineCapDischargeReq, .waveformEnable, .auxRegulatorEnable,
		.supplyClampEnable, .softStartEnable, .hvPassDeviceEnable,
		.hvHighCurrentLevel, .lowSideHold, .lineCapDischarge,
		.externalBiasMode, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData, .irq);

	far_side_model i_far (.clk, .reset_n, .softStartEnable, .fastFaultReq,
		.systemReady, .softStartDone, .outputOvervoltage, .peakOvercurrent);

	//----------------------------------------------------------------
	// Checks and bus tasks
	//----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task bail;
		fails++;
		summarize();
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask

	task rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
	endtask

	task wait_st(input logic [2:0] s);
		logic [31:0] d;
		for (int i = 0; i < 400; i++) begin
			rd(REG_STATUS, d);
			if (d[2:0] === s) begin
				chk(d[2:0], s);
				return;
			end
		end
		bail();
	endtask

	function automatic logic sig(int sel);
		case (sel)
			0: return lowSideHold;
			1: return waveformEnable;
			2: return hvPassDeviceEnable;
			default: return !waveformEnable;
		endcase
	endfunction

	// Edges until the selected output goes high, or for sel 3 until waveformEnable goes low
	task cnt(input int sel, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (n > 200)
				bail();
		end while (sig(sel) !== 1'b1);
	endtask

	task cap_pulse;
		@(posedge clk);
		lineCapDischargeReq <= 1'b1;
		@(posedge clk);
		lineCapDischargeReq <= 1'b0;
		#1 chk(lineCapDischarge, 1);
		@(posedge clk);
		#1 chk(lineCapDischarge, 0);
	endtask

	task set_fault(input int i, input logic v);
		case (i)
			0: overTemperature <= v;
			1: bulkOvervoltage <= v;
			2: bulkBelowStop <= v;
			3: auxRegUndervoltage <= v;
			4: fastFaultReq[0] <= v;
			5: fastFaultReq[1] <= v;
			6: avgOvercurrentShort <= v;
			default: avgOvercurrentLong <= v;
		endcase
	endtask

	//----------------------------------------------------------------
	// Main sequence
	//----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		int n;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		#1 chk({supplyClampEnable, hvPassDeviceEnable, waveformEnable,
			auxRegulatorEnable, softStartEnable}, 5'h18);
		rd(REG_STATUS, d);
		chk(d[2:0], 3'h0);
		cap_pulse();
		wait_st(3'h1);
		chk({supplyClampEnable, hvPassDeviceEnable, waveformEnable,
			auxRegulatorEnable, softStartEnable}, 5'h08);
		chk(hvHighCurrentLevel, 1);
		wr(REG_CTRL, 32'h1);
		rd(REG_CTRL, d);
		chk(d, 32'h1);
		chk(externalBiasMode, 1);
		wr(REG_CTRL, 32'h0);
		rd(8'h10, d);
		chk(d, 32'h0);
		@(posedge clk);
		lineZeroCrossSeen <= 1'b1;
		supplyAboveSwitchThreshold <= 1'b1;
		wait_st(3'h2);
		chk({auxRegulatorEnable, hvPassDeviceEnable}, 2'h2);
		rd(REG_STATUS, d);
		chk(d, 32'h0005_0002);
		@(posedge clk);
		bulkAboveStart <= 1'b1;
		cnt(0, n);
		chk(n, 3 + WU);
		chk({waveformEnable, softStartEnable, auxRegulatorEnable}, 1);
		cnt(1, n);
		chk(n, BT);
		chk({softStartEnable, auxRegulatorEnable, lowSideHold}, 6);
		$display("test start-up done");
		wait_st(3'h5);
		@(posedge clk);
		feedbackBelowBurstThreshold <= 1'b1;
		wait_st(3'h6);
		chk({waveformEnable, softStartEnable, auxRegulatorEnable}, 7);
		@(posedge clk);
		feedbackBelowBurstThreshold <= 1'b0;
		wait_st(3'h5);
		@(posedge clk);
		feedbackBelowBurstThreshold <= 1'b1;
		cnt(3, n);
		chk(n >= BU + 3 && n <= BU + 4, 1);
		chk({waveformEnable, softStartEnable, auxRegulatorEnable,
			supplyClampEnable, hvPassDeviceEnable}, 0);
		feedbackBelowBurstThreshold <= 1'b0;
		cnt(2, n);
		chk(n, PS);
		wait_st(3'h5);
		rd(REG_IRQ_STAT, d);
		chk(d, 32'hf);
		wr(REG_IRQ_STAT, 32'hf);
		rd(REG_IRQ_STAT, d);
		chk(d, 0);
		$display("test burst done");
		wr(REG_IRQ_MASK, 32'h2);
		@(posedge clk);
		supplyBelowRestart <= 1'b1;
		wait_st(3'h1);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1);
		wr(REG_IRQ_STAT, 32'h2);
		repeat (2) @(posedge clk);
		#1 chk(irq, 0);
		@(posedge clk);
		overTemperature <= 1'b1;
		wait_st(3'h7);
		@(posedge clk);
		overTemperature <= 1'b0;
		wait_st(3'h1);
		wr(REG_IRQ_MASK, 32'h0);
		supplyBelowRestart <= 1'b0;
		wait_st(3'h5);
		@(posedge clk);
		avgOvercurrentShort <= 1'b1;
		repeat (3) @(posedge clk);
		avgOvercurrentShort <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(waveformEnable, 1);
		$display("test restart done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			set_fault(i, 1'b1);
			cnt(3, n);
			chk(n <= AL + 5, 1);
			chk(i < 6 || n >= (i == 6 ? AS : AL) + 2, 1);
			@(posedge clk);
			set_fault(i, 1'b0);
			if (i == 0)
				cap_pulse();
			wait_st(3'h5);
		end
		$display("test faults done");
		summarize();
	end
endmodule
